/* File: hw/adcsp_params.svh */
// offsets, field positions, reset values and sizes for the sequencer priority arbiter
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH
`define ADCSP_ADDR_W        12
`define ADCSP_OFF_PRIORITY  12'h020
`define ADCSP_OFF_TRIGGER   12'h028
`define ADCSP_OFF_ENABLE    12'h000
`define ADCSP_OFF_STATUS    12'h004
`define ADCSP_NSEQ          4
`define ADCSP_RANK_W        2
`define ADCSP_PRIO_RESET    8'hE4
`define ADCSP_PRIO_MASK     32'h0000_3333
`define ADCSP_CONV_CYCLES   8'h10
`endif

/* File: hw/adcsp_pkg.sv */
// types shared by the sequencer priority arbiter
package adcsp_pkg;
   typedef logic [1:0] adcsp_rank_type;
   typedef logic [3:0] adcsp_mask_type;
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BUSY} adcsp_state_type;
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } adcsp_bus_type;
endpackage

/* File: hw/adcsp_pick.sv */
// combinational picker: most urgent pending sequencer by programmed rank
`timescale 1ns/1ns
module adcsp_pick
(
   // pending requests and ranks
   input  wire logic [3:0] pend,
   input  wire logic [7:0] ranks,
   // chosen sequencer
   output logic            found,
   output logic [1:0]      sel
);
   logic [3:0] hit [0:3];
   // for each rank value, which pending sequencers carry it
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_seq
         assign hit[0][g] = pend[g] && ranks[2*g +: 2] == 2'h0;
         assign hit[1][g] = pend[g] && ranks[2*g +: 2] == 2'h1;
         assign hit[2][g] = pend[g] && ranks[2*g +: 2] == 2'h2;
         assign hit[3][g] = pend[g] && ranks[2*g +: 2] == 2'h3;
      end
   endgenerate
   // lowest rank first; duplicate ranks fall back to lowest index
   always_comb
   begin
      found = 1'b0;
      sel   = 2'h0;
      for (int r = 3; r >= 0; r--)
      begin
         if (hit[r] != 4'h0)
         begin
            found = 1'b1;
            for (int s = 3; s >= 0; s--)
            begin
               if (hit[r][s])
               begin
                  sel = s[1:0];
               end
            end
         end
      end
   end
endmodule // adcsp_pick

/* File: hw/adcsp_top.sv */
// sequencer priority register, software trigger and start arbiter
// Operation
// R01 - four 2-bit ranks, reset to own index
// R02 - software keeps all ranks distinct
// R03 - one write triggers any sequencer combination
// R04 - simultaneous triggers run in rank order
// R05 - disabled sequencers ignore trigger bits
// R06 - trigger register write-only, reads have no effect
// R07 - trigger bit pends until granted; zeros ignored (here disabling a sequencer also clears its pending bit)
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`include "adcsp_params.svh"
module adcsp_top
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // register port
   input  wire logic [11:0] ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // converter side
   input  wire logic        CONV_DONE,
   output logic             CONV_START,
   output logic      [1:0]  CONV_SEQ,
   output logic      [3:0]  SEQ_ENABLE
);
   typedef struct packed
   {
      logic [7:0]               prio;
      logic [3:0]               enable;
      logic [3:0]               pend;
      adcsp_pkg::adcsp_state_type st;
      logic [1:0]               cur;
      logic                     start;
      logic [7:0]               cnt;
      logic [31:0]              rdata;
   } adcsp_state_reg_type;

   adcsp_state_reg_type s_r;
   adcsp_state_reg_type s_nxt;
   adcsp_pkg::adcsp_bus_type bus;
   logic                     found;
   logic [1:0]               sel;
   // checker helpers: more urgent pending sequencers per sequencer, timeout bound
   logic [3:0]               beat_m [0:3];
   localparam int            busy_max = `ADCSP_CONV_CYCLES;

   assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

   adcsp_pick u_pick
   (
      .pend  (s_r.pend),
      .ranks (s_r.prio),
      .found (found),
      .sel   (sel)
   );

   // next state: registers, pending set, arbitration
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.start = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      // writes
      if (bus.wr && bus.addr == `ADCSP_OFF_PRIORITY)
      begin
         s_nxt.prio = {bus.wdata[13:12], bus.wdata[9:8], bus.wdata[5:4], bus.wdata[1:0]}; // R01
      end
      if (bus.wr && bus.addr == `ADCSP_OFF_ENABLE)
      begin
         s_nxt.enable = bus.wdata[3:0];
      end
      // grant clears one pending bit; a new write below sets win over it
      if (s_r.st == adcsp_pkg::ST_IDLE && found)
      begin
         s_nxt.pend[sel] = 1'b0; // R04
         s_nxt.cur       = sel;
         s_nxt.start     = 1'b1;
         s_nxt.st        = adcsp_pkg::ST_BUSY;
         // load one short so the busy phase lasts exactly the timeout count
         s_nxt.cnt       = `ADCSP_CONV_CYCLES - 8'h01;
      end
      if (s_r.st == adcsp_pkg::ST_BUSY)
      begin
         // done from converter or internal timeout, whichever first
         if (CONV_DONE || s_r.cnt == 8'h00)
         begin
            s_nxt.st = adcsp_pkg::ST_IDLE;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt - 8'h01;
         end
      end
      // only ones set pending, and only on enabled sequencers
      if (bus.wr && bus.addr == `ADCSP_OFF_TRIGGER)
      begin
         s_nxt.pend = s_nxt.pend | (bus.wdata[3:0] & s_r.enable); // R03 R05 R07
      end
      // a disabled sequencer drops its stale request
      s_nxt.pend = s_nxt.pend & s_nxt.enable; // R05
      // reads; trigger register returns zero and changes nothing
      if (bus.rd)
      begin
         unique case (bus.addr)
            `ADCSP_OFF_PRIORITY:
               s_nxt.rdata = {18'h0_0000, s_r.prio[7:6], 2'h0, s_r.prio[5:4], 2'h0,
                              s_r.prio[3:2], 2'h0, s_r.prio[1:0]};
            `ADCSP_OFF_ENABLE: s_nxt.rdata = {28'h000_0000, s_r.enable};
            `ADCSP_OFF_STATUS:
               s_nxt.rdata = {25'h000_0000, s_r.st == adcsp_pkg::ST_BUSY, s_r.cur,
                              s_r.pend};
            default: s_nxt.rdata = 32'h0000_0000; // R06
         endcase
      end
      if (RST)
      begin
         s_nxt        = '0;
         s_nxt.prio   = `ADCSP_PRIO_RESET; // R01
         s_nxt.st     = adcsp_pkg::ST_IDLE;
      end
   end

   // state register
   always_ff @(posedge CLK)
   begin
      s_r <= s_nxt;
   end

   assign RDATA      = s_r.rdata;
   assign CONV_START = s_r.start;
   assign CONV_SEQ   = s_r.cur;
   assign SEQ_ENABLE = s_r.enable;

   // per sequencer, which pending sequencers hold a strictly more urgent rank;
   // only the checks read it, so the grant is judged apart from the picker
   genvar g;
   genvar h;
   generate
      for (g = 0; g < 4; g++)
      begin : g_beat
         for (h = 0; h < 4; h++)
         begin : g_other
            assign beat_m[g][h] = s_r.pend[h] && (s_r.prio[2*h +: 2] < s_r.prio[2*g +: 2]);
         end
      end
   endgenerate

   // out of reset: ranks equal own index, nothing enabled, no start
   chk_reset_ranks: assert property (@(posedge CLK) // R01
      $past(RST) |-> s_r.prio == `ADCSP_PRIO_RESET && SEQ_ENABLE == 4'h0 && !CONV_START)
      else $error("ranks not at reset value");

   // a rank write lands in the four two-bit fields, reserved bits dropped
   chk_prio_write: assert property (@(posedge CLK) disable iff (RST) // R01
      (WR && ADDR == `ADCSP_OFF_PRIORITY) |=> s_r.prio == {$past(WDATA[13:12]),
      $past(WDATA[9:8]), $past(WDATA[5:4]), $past(WDATA[1:0])})
      else $error("rank write lost");

   // a trigger to an enabled sequencer pends next cycle, even against a grant
   chk_trig_pend: assert property (@(posedge CLK) disable iff (RST) // R03
      (WR && ADDR == `ADCSP_OFF_TRIGGER && WDATA[0] && s_r.enable[0]) |=> s_r.pend[0])
      else $error("trigger lost");

   // disabled sequencer never pends
   chk_disabled_ign: assert property (@(posedge CLK) disable iff (RST) // R05
      (s_r.pend & ~s_r.enable) == 4'h0)
      else $error("disabled sequencer pending");

   // a trigger bit on a disabled sequencer is dropped at once
   chk_trig_disabled: assert property (@(posedge CLK) disable iff (RST) // R05
      (WR && ADDR == `ADCSP_OFF_TRIGGER && WDATA[3] && !s_r.enable[3]) |=> !s_r.pend[3])
      else $error("disabled sequencer took a trigger");

   // disabling a sequencer throws away its stale request
   chk_enable_drop: assert property (@(posedge CLK) disable iff (RST) // R05
      (WR && ADDR == `ADCSP_OFF_ENABLE && !WDATA[2]) |=> !s_r.pend[2])
      else $error("stale request kept after disable");

   // the grant goes to a pending sequencer with no more urgent rank pending
   chk_rank_order: assert property (@(posedge CLK) disable iff (RST) // R04
      (s_r.st == adcsp_pkg::ST_IDLE && found) |-> s_r.pend[sel] && beat_m[sel] == 4'h0)
      else $error("grant not by rank");

   // each grant is one start pulse naming the chosen sequencer
   chk_start_pulse: assert property (@(posedge CLK) disable iff (RST) // R04
      (s_r.st == adcsp_pkg::ST_IDLE && found) |=> CONV_START && CONV_SEQ == $past(sel))
      else $error("start missing after grant");

   // no start without a grant, so runs never overlap
   chk_start_grant: assert property (@(posedge CLK) disable iff (RST) // R04
      !(s_r.st == adcsp_pkg::ST_IDLE && found) |=> !CONV_START)
      else $error("start without grant");

   // a conversion never holds the arbiter longer than the timeout
   chk_busy_bound: assert property (@(posedge CLK) disable iff (RST) // R04
      CONV_START |-> ##[1:busy_max] s_r.st == adcsp_pkg::ST_IDLE)
      else $error("busy past timeout");

   // reading the trigger register returns zero and keeps pending bits
   chk_trig_read: assert property (@(posedge CLK) disable iff (RST) // R06
      (RD && !WR && ADDR == `ADCSP_OFF_TRIGGER && !(s_r.st == adcsp_pkg::ST_IDLE && found))
      |=> RDATA == 32'h0000_0000 && s_r.pend == $past(s_r.pend))
      else $error("trigger read had effect");

   // read data stand only after a read strobe
   chk_read_idle: assert property (@(posedge CLK) disable iff (RST) // R06
      !RD |=> RDATA == 32'h0000_0000)
      else $error("read data without a read");

   // a trigger write of zeros leaves pending bits alone
   chk_trig_zero: assert property (@(posedge CLK) disable iff (RST) // R07
      (WR && ADDR == `ADCSP_OFF_TRIGGER && WDATA[3:0] == 4'h0 &&
       !(s_r.st == adcsp_pkg::ST_IDLE && found)) |=> s_r.pend == $past(s_r.pend))
      else $error("zero trigger changed pending");

   // pending stays until granted or its sequencer is disabled
   chk_pend_hold: assert property (@(posedge CLK) disable iff (RST) // R07
      (s_r.pend[1] && s_r.enable[1] && !(WR && ADDR == `ADCSP_OFF_ENABLE) &&
       !(s_r.st == adcsp_pkg::ST_IDLE && sel == 2'h1)) |=> s_r.pend[1])
      else $error("pending dropped without grant");

endmodule // adcsp_top

/* File: bench/test_adc_sequencer_priority_trigger.sv */
// self-checking bench for the sequencer priority arbiter
`timescale 1ns/1ns
`include "adcsp_params.svh"
module test_adc_sequencer_priority_trigger;
   logic        clk;
   logic        rst;
   logic        wr;
   logic        rd;
   logic        conv_done;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        conv_start;
   logic [1:0]  conv_seq;
   logic [3:0]  seq_en;
   int          err_count;
   int          checks_done;
   int          cyc;

   adcsp_top dut_u
   (
      .CLK        (clk),
      .RST        (rst),
      .ADDR       (addr),
      .WDATA      (wdata),
      .WR         (wr),
      .RD         (rd),
      .RDATA      (rdata),
      .CONV_DONE  (conv_done),
      .CONV_START (conv_start),
      .CONV_SEQ   (conv_seq),
      .SEQ_ENABLE (seq_en)
   );

   // free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("errors=%0d checks=%0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // one-cycle write strobe, released at the next edge
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd32(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   // bounded wait for the next start, then finish it with a done pulse
   task automatic seq(input logic [1:0] s);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (conv_start !== 1'b1 && n < 40);
      chk({31'h0, conv_start}, 32'h0000_0001);
      chk({30'h0, conv_seq}, {30'h0, s});
      @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask

   // counted wait for a start that only the timeout can release
   task automatic tmo(input logic [1:0] s, input logic [31:0] e);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1 n++;
      end
      while (conv_start !== 1'b1 && n < 40);
      chk(n, e);
      chk({30'h0, conv_seq}, {30'h0, s});
   endtask

   // no start may appear for a while
   task automatic quiet();
      int n;
      n = 0;
      repeat (30)
      begin
         @(posedge clk);
         #1 n += int'(conv_start === 1'b1);
      end
      chk(n, 32'h0000_0000);
   endtask

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_count++;
         end_sim();
      end
   end

   initial
   begin
      {rst, wr, rd, conv_done, addr, wdata} = '0;
      {err_count, checks_done, cyc} = '0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd32(`ADCSP_OFF_PRIORITY, 32'h0000_3210);
      rd32(`ADCSP_OFF_TRIGGER, 32'h0000_0000);
      quiet();
      wr32(`ADCSP_OFF_ENABLE, 32'h0000_000F);
      wr32(`ADCSP_OFF_TRIGGER, 32'h0000_0005);
      seq(2'h0);
      seq(2'h2);
      quiet();
      wr32(`ADCSP_OFF_PRIORITY, 32'hFFFF_0123);
      rd32(`ADCSP_OFF_PRIORITY, 32'h0000_0123);
      wr32(`ADCSP_OFF_TRIGGER, 32'hFFFF_FFFF);
      seq(2'h3);
      seq(2'h2);
      seq(2'h1);
      seq(2'h0);
      quiet();
      wr32(`ADCSP_OFF_ENABLE, 32'h0000_0006);
      #1 chk({28'h0, seq_en}, 32'h0000_0006);
      rd32(`ADCSP_OFF_ENABLE, 32'h0000_0006);
      wr32(`ADCSP_OFF_TRIGGER, 32'h0000_000F);
      seq(2'h2);
      seq(2'h1);
      quiet();
      // seq2 runs with no done; seq1 waits behind it for the timeout
      wr32(`ADCSP_OFF_TRIGGER, 32'h0000_0004);
      wr32(`ADCSP_OFF_TRIGGER, 32'h0000_0002);
      rd32(`ADCSP_OFF_STATUS, 32'h0000_0062);
      rd32(`ADCSP_OFF_TRIGGER, 32'h0000_0000);
      // seq2 started five edges ago; starts lie timeout plus one idle cycle apart
      tmo(2'h1, `ADCSP_CONV_CYCLES - 4);
      wr32(`ADCSP_OFF_TRIGGER, 32'h0000_0000);
      quiet();
      rd32(`ADCSP_OFF_STATUS, 32'h0000_0010);
      end_sim();
   end
endmodule // test_adc_sequencer_priority_trigger
